// ### src/adcc_top.sv
`timescale 1ns/100ps
module adcc_top
    import adcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic [11:0] result_i,
    input wire logic lvr_en_i,
    input wire logic lvd_en_i,
    output logic core_rst_o,
    output logic core_pwr_dn_o,
    output logic conv_clk_o,
    output logic [3:0] ch_sel_o,
    output logic bg_route_o,
    output logic bg_on_o,
    output logic ref_ext_o,
    output logic [3:0] pin_analog_o,
    output logic [3:0] pull_high_off_o
);

    // divider terminal count for a clock field code
    function automatic logic [5:0] div_limit(input logic [2:0] code);
        logic [6:0] v;
        v = (7'h01 << code) - 7'h01;
        if (code == 3'h7) begin
            v = 7'h3f;
        end
        return v[5:0];
    endfunction : div_limit

    // result placement in the two data bytes
    function automatic logic [15:0] place(input logic [11:0] r, input logic right);
        return right ? {4'h0, r} : {r, 4'h0};
    endfunction : place

    logic [7:0] c0_q;
    logic [7:0] c1_q;
    logic [7:0] pin_q;
    logic busy_q;
    logic [7:0] irq_st_q;
    logic [7:0] irq_en_q;
    logic [11:0] res_q;
    logic [11:0] res_s1_q;
    logic [11:0] res_s2_q;
    logic [5:0] div_q;
    logic tick_q;
    logic [3:0] cnt_q;
    adcc_state_t st_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic irq_q;
    logic wr_stb;
    logic rd_stb;
    logic start;
    logic off;
    logic bg_sel;
    logic [2:0] div_code;
    logic [15:0] res_w;
    logic [7:0] c0_rd;
    logic done_set;
    logic last_tick;

    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
    assign rd_stb = wb_cyc_i && wb_stb_i && !ack_q;
    assign start = c0_q[C0_START];
    assign off = c0_q[C0_OFF];
    assign bg_sel = c1_q[C1_BG_SEL];
    assign div_code = c1_q[C1_DIV_HI:0];
    assign res_w = place(res_q, c0_q[C0_ALIGN]);
    assign c0_rd = (c0_q & C0_WMASK) | {1'b0, busy_q, 6'h00};
    assign done_set = (st_q == S_DONE);
    assign last_tick = (st_q == S_CONV) && tick_q && (cnt_q == CONV_LAST);

    // bus acknowledge, one cycle per request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    // read data mux, unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (rd_stb) begin
            unique case (wb_adr_i)
                A_RES_LO: rdat_q <= {24'h0, res_w[7:0]};
                A_RES_HI: rdat_q <= {24'h0, res_w[15:8]};
                A_CTRL0: rdat_q <= {24'h0, c0_rd};
                A_CTRL1: rdat_q <= {24'h0, c1_q & C1_WMASK};
                A_PIN_EN: rdat_q <= {24'h0, pin_q & PIN_WMASK};
                A_IRQ_ST: rdat_q <= {24'h0, irq_st_q};
                A_IRQ_EN: rdat_q <= {24'h0, irq_en_q};
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    // control register writes, only implemented bits stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c0_q <= C0_RST;
            c1_q <= C1_RST;
            pin_q <= PIN_RST;
            irq_en_q <= 8'h00;
        end else if (wr_stb) begin
            if (wb_adr_i == A_CTRL0) begin
                c0_q <= wb_dat_i[7:0] & C0_WMASK;
            end
            if (wb_adr_i == A_CTRL1) begin
                c1_q <= wb_dat_i[7:0] & C1_WMASK;
            end
            if (wb_adr_i == A_PIN_EN) begin
                pin_q <= wb_dat_i[7:0] & PIN_WMASK;
            end
            if (wb_adr_i == A_IRQ_EN) begin
                irq_en_q <= wb_dat_i[7:0] & IRQ_MASK;
            end
        end
    end

    // sticky interrupt status, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_q <= 8'h00;
        end else begin
            if (wr_stb && wb_adr_i == A_IRQ_CLR) begin
                irq_st_q <= (irq_st_q & ~wb_dat_i[7:0]) | {7'h00, done_set};
            end else begin
                irq_st_q <= irq_st_q | {7'h00, done_set};
            end
        end
    end

    // result input crosses from the analog core
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_s1_q <= 12'h000;
            res_s2_q <= 12'h000;
        end else begin
            res_s1_q <= result_i;
            res_s2_q <= res_s1_q;
        end
    end

    // converter clock divider, one tick per divided period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 6'h00;
            tick_q <= 1'b0;
        end else if (div_q >= div_limit(div_code)) begin
            div_q <= 6'h00;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 6'h01;
            tick_q <= 1'b0;
        end
    end

    // conversion sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= S_IDLE;
        end else begin
            unique case (st_q)
                S_IDLE: begin
                    if (start) begin
                        st_q <= S_RST;
                    end
                end
                S_RST: begin
                    if (!start) begin
                        st_q <= off ? S_IDLE : S_CONV;
                    end
                end
                S_CONV: begin
                    if (start) begin
                        st_q <= S_RST;
                    end else if (off) begin
                        st_q <= S_IDLE;
                    end else if (last_tick) begin
                        st_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    st_q <= start ? S_RST : S_IDLE;
                end
            endcase
        end
    end

    // tick counter within a conversion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
        end else if (st_q != S_CONV) begin
            cnt_q <= 4'h0;
        end else if (tick_q) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // result stored on the last tick, ahead of busy clearing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_q <= 12'h000;
        end else if (last_tick && !start && !off) begin
            res_q <= res_s2_q;
        end
    end

    // busy flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= BUSY_RST;
        end else if (start || st_q == S_RST) begin
            busy_q <= 1'b1;
        end else if (st_q == S_DONE) begin
            busy_q <= 1'b0;
        end
    end

    // registered outputs toward the core, pins and cpu
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_rst_o <= 1'b0;
            core_pwr_dn_o <= 1'b1;
            conv_clk_o <= 1'b0;
            ch_sel_o <= 4'h0;
            bg_route_o <= 1'b0;
            bg_on_o <= 1'b0;
            ref_ext_o <= 1'b0;
            pin_analog_o <= 4'h0;
            pull_high_off_o <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            core_rst_o <= start;
            core_pwr_dn_o <= off;
            conv_clk_o <= tick_q && (st_q == S_CONV);
            ch_sel_o <= bg_sel ? 4'h0 : (4'h1 << c0_q[1:0]);
            bg_route_o <= bg_sel;
            bg_on_o <= (c1_q[C1_BG_EN] && bg_sel) || lvr_en_i || lvd_en_i;
            ref_ext_o <= c1_q[C1_REF];
            pin_analog_o <= pin_q[3:0];
            pull_high_off_o <= pin_q[3:0];
            irq_q <= |(irq_st_q & irq_en_q);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o = irq_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_start_fall_conv: assert property (
        st_q == S_RST && !start && !off |=> st_q == S_CONV
    ) else $error("start release did not begin conversion");

    chk_start_held_rst: assert property (
        start [*2] |-> core_rst_o && busy_q
    ) else $error("held start did not reset and flag busy");

    chk_off_blocks: assert property (
        off [*2] |-> st_q != S_CONV && core_pwr_dn_o
    ) else $error("conversion running while powered off");

    chk_left_align_zero: assert property (
        ack_q && $past(rd_stb) && $past(wb_adr_i) == A_RES_LO && !$past(c0_q[C0_ALIGN])
        |-> wb_dat_o == {24'h0, $past(res_q[3:0]), 4'h0}
    ) else $error("left aligned low byte wrong");

    chk_right_align_zero: assert property (
        ack_q && $past(rd_stb) && $past(wb_adr_i) == A_RES_HI && $past(c0_q[C0_ALIGN])
        |-> wb_dat_o == {28'h0, $past(res_q[11:8])}
    ) else $error("right aligned high byte wrong");

    chk_ctrl_unimpl_zero: assert property (
        ack_q && $past(wb_adr_i) == A_CTRL0 && $past(rd_stb) |-> wb_dat_o[3:2] == 2'b00
    ) else $error("unimplemented control bits read nonzero");

    chk_bg_route_cut: assert property (
        bg_sel |=> ch_sel_o == 4'h0 && bg_route_o
    ) else $error("bandgap select left external channel");

    chk_done_flags: assert property (
        st_q == S_DONE && !start |=> !busy_q && irq_st_q[IRQ_DONE]
    ) else $error("end of conversion flags wrong");

    chk_conv_length: assert property (
        st_q == S_CONV && cnt_q == CONV_LAST && tick_q && !start && !off
        |=> st_q == S_DONE && res_q == $past(res_s2_q)
    ) else $error("conversion end or result capture wrong");

    chk_div_by_two: assert property (
        tick_q && div_code == 3'h1 ##1 div_code == 3'h1 |-> !tick_q ##1 tick_q
    ) else $error("divide by two spacing wrong");

    chk_bg_auto_off: assert property (
        !bg_sel && !lvr_en_i && !lvd_en_i |=> !bg_on_o
    ) else $error("bandgap left on while unused");

endmodule : adcc_top

// ### src/adcc_pkg.sv
package adcc_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] A_RES_LO = 8'h00;
    localparam logic [7:0] A_RES_HI = 8'h04;
    localparam logic [7:0] A_CTRL0 = 8'h08;
    localparam logic [7:0] A_CTRL1 = 8'h0c;
    localparam logic [7:0] A_PIN_EN = 8'h10;
    localparam logic [7:0] A_IRQ_ST = 8'h14;
    localparam logic [7:0] A_IRQ_CLR = 8'h18;
    localparam logic [7:0] A_IRQ_EN = 8'h1c;
    // converter_control_zero fields
    localparam int C0_START = 7;
    localparam int C0_BUSY = 6;
    localparam int C0_OFF = 5;
    localparam int C0_ALIGN = 4;
    // converter_control_one fields
    localparam int C1_BG_SEL = 7;
    localparam int C1_BG_EN = 6;
    localparam int C1_REF = 4;
    localparam int C1_DIV_HI = 2;
    // implemented, writable bits
    localparam logic [7:0] C0_WMASK = 8'hb3;
    localparam logic [7:0] C1_WMASK = 8'hd7;
    localparam logic [7:0] PIN_WMASK = 8'h0f;
    // reset values
    localparam logic [7:0] C0_RST = 8'h20;
    localparam logic BUSY_RST = 1'b1;
    localparam logic [7:0] C1_RST = 8'h00;
    localparam logic [7:0] PIN_RST = 8'h0f;
    // interrupt status layout
    localparam int IRQ_DONE = 0;
    localparam logic [7:0] IRQ_MASK = 8'h01;
    // conversion length in divided converter clock ticks
    localparam int CONV_TICKS = 16;
    localparam logic [3:0] CONV_LAST = 4'(CONV_TICKS - 1);
    // sequencer states
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_CONV = 2'b11,
        S_DONE = 2'b01,
        S_RST = 2'b10
    } adcc_state_t;
endpackage : adcc_pkg

// ### dv/adcc_core_model.sv
`timescale 1ns/100ps
// analog core stand-in: a fixed sample while powered, a churning value while down
module adcc_core_model #(
    parameter logic [11:0] RES = 12'ha5c
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pwr_dn_i,
    output logic [11:0] result_o
);
    // powered-down core gives nothing usable, so the bus never rests on a stale value
    always @(posedge clk_i) begin
        if (rst_i) result_o <= 12'h000;
        else result_o <= pwr_dn_i ? ~result_o : RES;
    end
endmodule : adcc_core_model

// ### dv/adcc_top_bench.sv
`timescale 1ns/100ps
module adcc_top_bench
    import adcc_pkg::*;
;
    typedef struct packed {
        logic we; logic [7:0] a; logic [3:0] s; logic [7:0] d; logic [7:0] e;
    } adcc_row_t;
    localparam logic [11:0] RES = 12'ha5c;
    // cycles allowed for the bandgap to settle before converting on it
    localparam int BG_SETTLE = 20;
    // register rows: reset values, masked bits, sel gating, unmapped space
    localparam adcc_row_t ROWS [15] = '{
        '{1'b0, A_CTRL0, 4'hf, 8'h00, 8'h60}, '{1'b0, A_CTRL1, 4'hf, 8'h00, 8'h00},
        '{1'b0, A_PIN_EN, 4'hf, 8'h00, 8'h0f}, '{1'b0, A_IRQ_ST, 4'hf, 8'h00, 8'h00},
        '{1'b0, 8'h20, 4'hf, 8'h00, 8'h00}, '{1'b1, A_CTRL1, 4'hf, 8'hff, 8'h00},
        '{1'b0, A_CTRL1, 4'hf, 8'h00, 8'hd7}, '{1'b1, A_PIN_EN, 4'hf, 8'hff, 8'h00},
        '{1'b0, A_PIN_EN, 4'hf, 8'h00, 8'h0f}, '{1'b1, A_CTRL1, 4'he, 8'h00, 8'h00},
        '{1'b0, A_CTRL1, 4'hf, 8'h00, 8'hd7}, '{1'b1, 8'h20, 4'hf, 8'hff, 8'h00},
        '{1'b0, A_IRQ_CLR, 4'hf, 8'h00, 8'h00}, '{1'b1, A_PIN_EN, 4'hf, 8'h05, 8'h00},
        '{1'b0, A_PIN_EN, 4'hf, 8'h00, 8'h05}};
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, low_voltage_reset = 1'b0, low_voltage_detect = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, irq, crst, pdn, cclk, bgr, bgon, refx;
    logic [3:0] chs, pin, pho;
    logic [11:0] res;
    logic [7:0] r;
    int err_count = 0, total_checks = 0, sc, t, t0, t1;

    adcc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .result_i(res), .lvr_en_i(low_voltage_reset), .lvd_en_i(low_voltage_detect), .core_rst_o(crst),
        .core_pwr_dn_o(pdn), .conv_clk_o(cclk), .ch_sel_o(chs), .bg_route_o(bgr),
        .bg_on_o(bgon), .ref_ext_o(refx), .pin_analog_o(pin), .pull_high_off_o(pho));
    adcc_core_model #(.RES(RES)) core (.clk_i(clk_i), .rst_i(rst_i), .pwr_dn_i(pdn),
        .result_o(res));

    // 10 MHz system clock
    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic finish_test;
        if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // one classic cycle; held until ack is sampled at an edge, read data taken there
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
            input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 50) begin
            err_count++;
            finish_test();
        end
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, 4'hf);
        check($sformatf("reg %h", a), {24'h0, r}, {24'h0, e});
    endtask : rd

    // counts converter strobes over n cycles or until irq rises
    task automatic watch(input int n, input logic to_irq);
        sc = 0; t = 0; t0 = 0; t1 = 0;
        while (t < n && !(to_irq && irq === 1'b1)) begin
            @(posedge clk_i);
            t++;
            if (cclk === 1'b1) begin
                if (sc == 0) t0 = t;
                if (sc == 1) t1 = t;
                sc++;
            end
        end
        if (to_irq && irq !== 1'b1) begin
            err_count++;
            finish_test();
        end
    endtask : watch

    initial begin
        tick(5);
        rst_i <= 1'b0;
        foreach (ROWS[i]) begin
            wb(ROWS[i].we, ROWS[i].a, ROWS[i].d, ROWS[i].s);
            if (!ROWS[i].we) check($sformatf("row %0d", i), {24'h0, r}, {24'h0, ROWS[i].e});
        end
        check("pin analog", {28'h0, pin}, 32'h5);
        check("pull high off", {28'h0, pho}, 32'h5);
        check("power down", {31'h0, pdn}, 32'h1);
        wr(A_CTRL1, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(A_CTRL0, 8'(c));
            tick(3);
            check("channel", {28'h0, chs}, 32'(4'h1 << c));
        end
        wr(A_CTRL1, 8'h40);
        wr(A_CTRL1, 8'hc0);
        tick(3);
        check("bg route", {chs, 3'h0, bgr, bgon}, 32'h3);
        // one conversion on the bandgap, started only after it has settled
        tick(BG_SETTLE);
        wr(A_CTRL0, 8'h80);
        wr(A_CTRL0, 8'h00);
        watch(100, 1'b0);
        check("bg strobes", sc, 16);
        rd(A_IRQ_ST, 8'h01);
        wr(A_IRQ_CLR, 8'h01);
        wr(A_CTRL1, 8'h80);
        tick(3);
        check("bg off", {31'h0, bgon}, 32'h0);
        low_voltage_detect <= 1'b1;
        tick(3);
        check("bg lvd", {31'h0, bgon}, 32'h1);
        low_voltage_detect <= 1'b0; low_voltage_reset <= 1'b1;
        tick(3);
        check("bg lvr", {31'h0, bgon}, 32'h1);
        low_voltage_reset <= 1'b0;
        wr(A_IRQ_EN, 8'h01);
        for (int k = 0; k < 8; k++) begin
            wr(A_CTRL1, {3'h0, k[0], 1'b0, k[2:0]});
            wr(A_CTRL0, {1'b1, 2'b00, k[0], 4'h0});
            watch(20, 1'b0);
            check("held start", {sc[7:0], 7'h0, crst}, 32'h1);
            rd(A_CTRL0, {1'b1, 2'b10, k[0], 4'h0});
            check("ref select", {31'h0, refx}, {31'h0, k[0]});
            wr(A_CTRL0, {3'h0, k[0], 4'h0});
            watch(3000, 1'b1);
            check("strobes", sc, 16);
            check("tick spacing", t1 - t0, 1 << (k == 7 ? 6 : k));
            check("irq raised", {31'h0, irq}, 32'h1);
            rd(A_CTRL0, {3'h0, k[0], 4'h0});
            rd(A_IRQ_ST, 8'h01);
            rd(A_RES_HI, k[0] ? {4'h0, RES[11:8]} : RES[11:4]);
            rd(A_RES_LO, k[0] ? RES[7:0] : {RES[3:0], 4'h0});
            wr(A_IRQ_EN, 8'h00);
            tick(3);
            check("irq masked", {31'h0, irq}, 32'h0);
            wr(A_IRQ_EN, 8'h01);
            wr(A_IRQ_CLR, 8'h01);
            tick(3);
            check("irq cleared", {31'h0, irq}, 32'h0);
        end
        // powered down: releasing start must not convert
        wr(A_CTRL0, 8'ha0);
        wr(A_CTRL0, 8'h20);
        watch(200, 1'b0);
        check("off strobes", {sc[30:0], pdn}, 32'h1);
        rd(A_IRQ_ST, 8'h00);
        // reset again in mid-conversion
        wr(A_CTRL0, 8'h80);
        wr(A_CTRL0, 8'h00);
        tick(10);
        rst_i <= 1'b1;
        tick(5);
        rst_i <= 1'b0;
        tick(2);
        check("irq after reset", {31'h0, irq}, 32'h0);
        rd(A_CTRL0, 8'h60);
        rd(A_PIN_EN, 8'h0f);
        finish_test();
    end
endmodule : adcc_top_bench
